/* File: gpt_pkg.sv */
// Purpose: Shared constants and types for the gated 16-bit timer.
// Assumes: APB slave with 32-bit data, one word per register.
// Notes:   Register indices are scaled by four to form byte addresses.
package gpt_pkg;

  localparam int unsigned CNT_W   = 16;
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned DATA_W  = 32;

  // Register indices; byte address is four times the index.
  localparam logic [ADDR_W-1:0] CNT_IDX = 16'h0100;
  localparam logic [ADDR_W-1:0] PER_IDX = 16'h0102;
  localparam logic [ADDR_W-1:0] CTL_IDX = 16'h0104;
  localparam logic [ADDR_W-1:0] STS_IDX = 16'h0106;
  localparam logic [ADDR_W-1:0] MSK_IDX = 16'h0108;

  // Control register bit positions.
  localparam int unsigned CTL_ON_POS    = 15;
  localparam int unsigned CTL_IDLE_POS  = 13;
  localparam int unsigned CTL_GATE_POS  = 6;
  localparam int unsigned CTL_PS_POS    = 4;
  localparam int unsigned CTL_SYNC_POS  = 2;
  localparam int unsigned CTL_SRC_POS   = 1;

  // Status and mask bit positions.
  localparam int unsigned EVT_W         = 2;
  localparam int unsigned EVT_MATCH_POS = 0;
  localparam int unsigned EVT_GATE_POS  = 1;

  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] PER_RST = 16'hFFFF;

  // Prescaler terminal counts for 1:1, 1:8, 1:64 and 1:256.
  localparam int unsigned PS_W = 8;
  localparam logic [PS_W-1:0] PS_LAST_1   = 8'h00;
  localparam logic [PS_W-1:0] PS_LAST_8   = 8'h07;
  localparam logic [PS_W-1:0] PS_LAST_64  = 8'h3F;
  localparam logic [PS_W-1:0] PS_LAST_256 = 8'hFF;

  typedef struct packed {
    logic       timer_on_bit;
    logic       idle_stop_bit;
    logic       gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic       external_sync_select;
    logic       clock_source_select;
  } gpt_ctrl_t;

  localparam gpt_ctrl_t CTRL_RST = '0;

  function automatic logic [ADDR_W-1:0] gpt_byte_addr(input logic [ADDR_W-1:0] idx);
    gpt_byte_addr = {idx[ADDR_W-3:0], 2'b00};
  endfunction : gpt_byte_addr

endpackage : gpt_pkg

/* File: gpt_timer.sv */
// Purpose: 16-bit timer/counter with period match, gating and prescaler.
// Assumes: Pin and CPU power-state inputs are synchronous to core_clk_i.
// Notes:   Instruction cycles come from a divider enable; default is every clock.
`timescale 1ns/100ps

module gpt_timer #(
  parameter int unsigned CYC_DIV = 1
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [gpt_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [gpt_pkg::DATA_W-1:0] pwdata_i,
  input  wire logic                       external_clock_gate_pin_i,
  input  wire logic                       cpu_idle_i,
  input  wire logic                       cpu_sleep_i,
  output logic      [gpt_pkg::DATA_W-1:0] prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  output logic                            irq_o
);

  localparam int unsigned DIV_W = (CYC_DIV > 1) ? $clog2(CYC_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_DIV - 1);

  logic [gpt_pkg::CNT_W-1:0] count_value_q, count_value_d;
  logic [gpt_pkg::CNT_W-1:0] period_value_q, period_value_d;
  gpt_pkg::gpt_ctrl_t        timer_control_q, timer_control_d;
  logic [gpt_pkg::EVT_W-1:0] status_q, status_d;
  logic [gpt_pkg::EVT_W-1:0] irq_mask_q, irq_mask_d;
  logic [gpt_pkg::PS_W-1:0]  ps_cnt_q, ps_cnt_d;
  logic [DIV_W-1:0]          div_q, div_d;
  logic                      sync1_q, sync2_q, sync3_q;
  logic                      raw_q, raw_prev_q;
  logic [gpt_pkg::DATA_W-1:0] prdata_q, prdata_d;
  logic                      pready_q, pready_d;
  logic                      pslverr_q, pslverr_d;
  logic                      irq_q, irq_d;

  logic                      instr_tick;
  logic                      acc, wr, rd, hit;
  logic                      wr_cnt, wr_ctl, rd_sts;
  logic                      gated, run, in_evt, adv, match, gate_fall;
  logic                      sync_rise, raw_rise;
  logic [gpt_pkg::PS_W-1:0]  ps_last;
  logic [gpt_pkg::EVT_W-1:0] evt;
  logic [gpt_pkg::CNT_W-1:0] wdata16;

  // Instruction-cycle enable from a divider of the core clock.
  always_comb begin
    div_d      = (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
    instr_tick = (div_q == DIV_LAST);
  end

  // Pin capture: a two-stage synchroniser plus an edge stage, and a raw path.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q      <= '0;
      sync1_q    <= 1'b0;
      sync2_q    <= 1'b0;
      sync3_q    <= 1'b0;
      raw_q      <= 1'b0;
      raw_prev_q <= 1'b0;
    end else begin
      div_q      <= div_d;
      sync1_q    <= external_clock_gate_pin_i;
      sync2_q    <= sync1_q;
      sync3_q    <= sync2_q;
      raw_q      <= external_clock_gate_pin_i;
      raw_prev_q <= raw_q;
    end
  end

  // APB decode; the access completes in the cycle after setup.
  always_comb begin
    acc     = psel_i & penable_i & pready_q;
    wr      = acc & pwrite_i;
    rd      = acc & ~pwrite_i;
    wdata16 = pwdata_i[gpt_pkg::CNT_W-1:0];
    hit     = (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::CNT_IDX)) |
              (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::PER_IDX)) |
              (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::CTL_IDX)) |
              (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::STS_IDX)) |
              (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::MSK_IDX));
    wr_cnt  = wr & (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::CNT_IDX));
    wr_ctl  = wr & (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::CTL_IDX));
    rd_sts  = rd & (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::STS_IDX));
  end

  // Count-input selection and run qualification.
  always_comb begin
    sync_rise = sync2_q & ~sync3_q;
    raw_rise  = raw_q & ~raw_prev_q;
    gated     = timer_control_q.gate_accumulate_enable & timer_control_q.timer_on_bit &
                ~timer_control_q.clock_source_select;
    gate_fall = gated & ~sync2_q & sync3_q;
    if (timer_control_q.clock_source_select) begin
      in_evt = timer_control_q.external_sync_select ? sync_rise : raw_rise;
    end else begin
      in_evt = instr_tick & (~gated | sync2_q);
    end
    run = timer_control_q.timer_on_bit &
          ~(cpu_idle_i & timer_control_q.idle_stop_bit) &
          ~(cpu_sleep_i & ~(timer_control_q.clock_source_select &
                            ~timer_control_q.external_sync_select));
  end

  // Prescaler and counter.
  always_comb begin
    unique case (timer_control_q.prescale_select)
      2'b00: ps_last = gpt_pkg::PS_LAST_1;
      2'b01: ps_last = gpt_pkg::PS_LAST_8;
      2'b10: ps_last = gpt_pkg::PS_LAST_64;
      2'b11: ps_last = gpt_pkg::PS_LAST_256;
    endcase
    adv      = 1'b0;
    ps_cnt_d = ps_cnt_q;
    if (wr_cnt | ~timer_control_q.timer_on_bit) begin
      ps_cnt_d = '0;
    end else if (run & in_evt) begin
      if (ps_cnt_q >= ps_last) begin
        ps_cnt_d = '0;
        adv      = 1'b1;
      end else begin
        ps_cnt_d = ps_cnt_q + 1'b1;
      end
    end
    match         = adv & (count_value_q == period_value_q);
    count_value_d = count_value_q;
    // count write loads, control write does not touch
    if (wr_cnt) begin
      count_value_d = wdata16;
    end else if (adv) begin
      // wrap to zero on period match
      count_value_d = match ? gpt_pkg::CNT_RST : count_value_q + 1'b1;
    end
  end

  // Registers written by software, and the sticky event flags.
  always_comb begin
    period_value_d  = period_value_q;
    timer_control_d = timer_control_q;
    irq_mask_d      = irq_mask_q;
    if (wr & (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::PER_IDX))) begin
      period_value_d = wdata16;
    end
    if (wr_ctl) begin
      timer_control_d.timer_on_bit           = pwdata_i[gpt_pkg::CTL_ON_POS];
      timer_control_d.idle_stop_bit          = pwdata_i[gpt_pkg::CTL_IDLE_POS];
      timer_control_d.gate_accumulate_enable = pwdata_i[gpt_pkg::CTL_GATE_POS];
      timer_control_d.prescale_select        = pwdata_i[gpt_pkg::CTL_PS_POS +: 2];
      timer_control_d.external_sync_select   = pwdata_i[gpt_pkg::CTL_SYNC_POS];
      timer_control_d.clock_source_select    = pwdata_i[gpt_pkg::CTL_SRC_POS];
    end
    if (wr & (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::MSK_IDX))) begin
      irq_mask_d = pwdata_i[gpt_pkg::EVT_W-1:0];
    end
    evt                          = '0;
    evt[gpt_pkg::EVT_MATCH_POS]  = match;
    evt[gpt_pkg::EVT_GATE_POS]   = gate_fall;
    // sticky until read; a new event beats the clear
    status_d = (rd_sts ? '0 : status_q) | evt;
    irq_d    = |(status_d & irq_mask_d);
  end

  // Read mux and slave answer.
  always_comb begin
    prdata_d  = '0;
    pready_d  = psel_i & ~penable_i & ~pready_q;
    pslverr_d = psel_i & ~penable_i & ~pready_q & ~hit;
    if (psel_i & ~penable_i & ~pwrite_i) begin
      if (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::CNT_IDX)) begin
        prdata_d[gpt_pkg::CNT_W-1:0] = count_value_q;
      end else if (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::PER_IDX)) begin
        prdata_d[gpt_pkg::CNT_W-1:0] = period_value_q;
      end else if (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::CTL_IDX)) begin
        prdata_d[gpt_pkg::CTL_ON_POS]    = timer_control_q.timer_on_bit;
        prdata_d[gpt_pkg::CTL_IDLE_POS]  = timer_control_q.idle_stop_bit;
        prdata_d[gpt_pkg::CTL_GATE_POS]  = timer_control_q.gate_accumulate_enable;
        prdata_d[gpt_pkg::CTL_PS_POS +: 2] = timer_control_q.prescale_select;
        prdata_d[gpt_pkg::CTL_SYNC_POS]  = timer_control_q.external_sync_select;
        prdata_d[gpt_pkg::CTL_SRC_POS]   = timer_control_q.clock_source_select;
      end else if (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::STS_IDX)) begin
        // Status is sampled at setup; an event in the access cycle survives the clear.
        prdata_d[gpt_pkg::EVT_W-1:0] = status_q | evt;
      end else if (paddr_i == gpt_pkg::gpt_byte_addr(gpt_pkg::MSK_IDX)) begin
        prdata_d[gpt_pkg::EVT_W-1:0] = irq_mask_q;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_value_q   <= gpt_pkg::CNT_RST;
      period_value_q  <= gpt_pkg::PER_RST;
      timer_control_q <= gpt_pkg::CTRL_RST;
      status_q        <= '0;
      irq_mask_q      <= '0;
      ps_cnt_q        <= '0;
      prdata_q        <= '0;
      pready_q        <= 1'b0;
      pslverr_q       <= 1'b0;
      irq_q           <= 1'b0;
    end else begin
      count_value_q   <= count_value_d;
      period_value_q  <= period_value_d;
      timer_control_q <= timer_control_d;
      status_q        <= status_d;
      irq_mask_q      <= irq_mask_d;
      ps_cnt_q        <= ps_cnt_d;
      prdata_q        <= prdata_d;
      pready_q        <= pready_d;
      pslverr_q       <= pslverr_d;
      irq_q           <= irq_d;
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;
  assign irq_o     = irq_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_no_adv(cond);
    cond |-> !adv;
  endproperty

  apb_ready_a: assert property (psel_i && !penable_i && !pready_o |=> pready_o)
    else $error("APB access phase did not see pready.");

  wrap_zero_a: assert property (match && !wr_cnt |=> count_value_q == gpt_pkg::CNT_RST)
    else $error("Count did not return to zero after period match.");

  idle_halt_a: assert property (p_no_adv(cpu_idle_i && timer_control_q.idle_stop_bit))
    else $error("Count advanced during Idle with idle stop set.");

  off_hold_a: assert property (!timer_control_q.timer_on_bit && !wr_cnt
                               |=> $stable(count_value_q))
    else $error("Count changed while the timer was off.");

  gate_low_a: assert property (p_no_adv(gated && !sync2_q))
    else $error("Gated count advanced with the gate low.");

  ps_clear_a: assert property (wr_cnt || !timer_control_q.timer_on_bit
                               |=> ps_cnt_q == '0)
    else $error("Prescaler not cleared.");

  ctl_keep_a: assert property (wr_ctl && !adv |=> $stable(count_value_q))
    else $error("Control write changed the count.");

  flag_irq_a: assert property (match |=> status_q[gpt_pkg::EVT_MATCH_POS]
                               && (irq_o == irq_mask_q[gpt_pkg::EVT_MATCH_POS] ||
                                   irq_mask_q[gpt_pkg::EVT_GATE_POS]))
    else $error("Match flag or interrupt missing after period match.");

  gate_evt_a: assert property (gate_fall |=> status_q[gpt_pkg::EVT_GATE_POS])
    else $error("Gate falling edge did not set its flag.");

  sleep_gate_a: assert property (p_no_adv(cpu_sleep_i &&
                                 !(timer_control_q.clock_source_select &&
                                   !timer_control_q.external_sync_select)))
    else $error("Count advanced in Sleep outside asynchronous external mode.");

  wrap_cov_c: cover property (match ##1 count_value_q == gpt_pkg::CNT_RST);
  gate_cov_c: cover property (gate_fall ##1 irq_o);
  rdclr_cov_c: cover property (rd_sts && status_q != '0 ##1 status_q == '0);

endmodule : gpt_timer

/* File: gpt_src.sv */
// Purpose: Drives the external clock or gate pin of the timer.
// Assumes: The pin changes right after a rising edge of core_clk_i.
// Notes:   The pin rests low between bursts, as an idle clock line would.
`timescale 1ns/100ps
module gpt_src (
  input  wire logic core_clk_i,
  output logic      pin_o
);
  initial pin_o = 1'b0;

  // edges wide enough
  // Each level lasts at least two cycles so a two-flop synchroniser sees every edge.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge core_clk_i) pin_o <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      pin_o <= 1'b0;
      repeat (2) @(posedge core_clk_i);
    end
  endtask : pulses

  task automatic gate(input int h);
    @(posedge core_clk_i) pin_o <= 1'b1;
    repeat (h) @(posedge core_clk_i);
    pin_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask : gate
endmodule : gpt_src

/* File: gp_timer16_gated_test.sv */
// Purpose: Self-checking bench for the gated 16-bit timer against a counting model.
// Assumes: APB master with one idle cycle between transfers.
// Notes:   Timer-mode interrupt timing is checked in a window, pin modes exactly.
`timescale 1ns/100ps
`define CHK(g, e) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module gp_timer16_gated_test;
  logic        core_clk_i, rst_n_i, psel, pen, pwr, pready, pslverr, irq, pin, idle, sleep;
  logic [15:0] paddr, lf;
  logic [31:0] pwdata, prdata, rd;
  logic        err;
  int          bad_count, n_checks, cyc, m_cnt, m_per, m_pre, m_flag, div, t, p;
  int          divs[4] = '{1, 8, 64, 256};
  localparam logic [15:0] A_CNT = gpt_pkg::CNT_IDX << 2;
  localparam logic [15:0] A_PER = gpt_pkg::PER_IDX << 2;
  localparam logic [15:0] A_CTL = gpt_pkg::CTL_IDX << 2;
  localparam logic [15:0] A_STS = gpt_pkg::STS_IDX << 2;
  localparam logic [15:0] A_MSK = gpt_pkg::MSK_IDX << 2;

  gpt_timer u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .external_clock_gate_pin_i(pin),
    .cpu_idle_i(idle), .cpu_sleep_i(sleep), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq));
  gpt_src u_src (.core_clk_i(core_clk_i), .pin_o(pin));

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // The hang limit is several times the longest prescaled run.
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    pen <= 1'b1;
    // A slave that never answers is caught by the cycle ceiling, not by a local limit.
    do begin
      @(posedge core_clk_i);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic chk_rd(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask : chk_rd

  task automatic mdl(input int n);
    repeat (n) begin
      m_pre++;
      if (m_pre == div) begin
        m_pre = 0;
        if (m_cnt == m_per) begin m_cnt = 0; m_flag = 1; end
        else m_cnt++;
      end
    end
  endtask : mdl

  task automatic cfg(input logic [15:0] ctl, input int per);
    apb(1'b1, A_CTL, 32'h0000_0000);
    apb(1'b1, A_PER, 32'(per));
    apb(1'b1, A_CNT, 32'h0000_0000);
    apb(1'b0, A_STS, 32'h0000_0000);
    apb(1'b1, A_CTL, {16'h0000, ctl});
    m_cnt = 0; m_pre = 0; m_flag = 0; m_per = per; div = divs[ctl[5:4]];
  endtask : cfg

  // Pulses reach the model only when the mode is expected to count them.
  task automatic run(input int n, input bit en);
    u_src.pulses(n);
    repeat (3) @(posedge core_clk_i);
    if (en) mdl(n);
    chk_rd(A_CNT, 32'(m_cnt));
  endtask : run

  initial begin
    rst_n_i = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 16'h0000;
    pwdata = 32'h0000_0000; idle = 1'b0; sleep = 1'b0; lf = 16'h17fe;
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    chk_rd(A_CNT, 32'h0000_0000);
    chk_rd(A_PER, 32'h0000_ffff);
    chk_rd(A_CTL, 32'h0000_0000);
    chk_rd(A_STS, 32'h0000_0000);
    chk_rd(A_MSK, 32'h0000_0000);
    chk_rd(16'h0404, 32'h0000_0000);
    `CHK(err, 1'b1)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      cfg(16'h8002 | 16'(i << 4), 16'hffff);
      run(2 * divs[i] + 3, 1'b1);
      lf = lfsr(lf);
      apb(1'b1, A_CNT, {16'h0000, lf});
      m_cnt = lf;
      m_pre = 0;
      chk_rd(A_CNT, 32'(m_cnt));
    end
    $display("test prescale done");
    lf = lfsr(lf);
    cfg(16'h8002, int'(lf[2:0]) + 3);
    run(int'(lf[6:3]) + m_per + 2, 1'b1);
    `CHK(irq, 1'b0)
    chk_rd(A_STS, 32'(m_flag));
    chk_rd(A_STS, 32'h0000_0000);
    apb(1'b1, A_MSK, 32'h0000_0001);
    m_flag = 0;
    run(m_per + 1, 1'b1);
    `CHK(irq, 1'b1)
    chk_rd(A_STS, 32'(m_flag));
    repeat (3) @(posedge core_clk_i);
    `CHK(irq, 1'b0)
    $display("test wrap done");
    cfg(16'h8006, 16'hffff);
    run(5, 1'b1);
    idle <= 1'b1;
    apb(1'b1, A_CTL, 32'h0000_a006);
    run(4, 1'b0);
    idle <= 1'b0;
    run(3, 1'b1);
    apb(1'b1, A_CTL, 32'h0000_8006);
    idle <= 1'b1;
    run(3, 1'b1);
    idle <= 1'b0;
    sleep <= 1'b1;
    run(3, 1'b0);
    sleep <= 1'b0;
    cfg(16'ha002, 16'hffff);
    idle <= 1'b1;
    run(3, 1'b0);
    idle <= 1'b0;
    sleep <= 1'b1;
    run(4, 1'b1);
    sleep <= 1'b0;
    apb(1'b1, A_CTL, 32'h0000_0002);
    run(4, 1'b0);
    $display("test counter modes done");
    lf = lfsr(lf);
    cfg(16'h8040, 16'hffff);
    apb(1'b1, A_MSK, 32'h0000_0002);
    m_cnt = int'(lf[4:0]) + 4;
    u_src.gate(m_cnt);
    repeat (3) @(posedge core_clk_i);
    `CHK(irq, 1'b1)
    chk_rd(A_CNT, 32'(m_cnt));
    chk_rd(A_STS, 32'h0000_0002);
    cfg(16'h8042, 16'hffff);
    u_src.gate(m_cnt + 5);
    repeat (3) @(posedge core_clk_i);
    chk_rd(A_CNT, 32'h0000_0001);
    chk_rd(A_STS, 32'h0000_0000);
    $display("test gate done");
    idle <= 1'b1;
    cfg(16'ha000, 16'hffff);
    repeat (20) @(posedge core_clk_i);
    chk_rd(A_CNT, 32'h0000_0000);
    lf = lfsr(lf);
    p = int'(lf[3:0]) + 4;
    cfg(16'h8000, p);
    apb(1'b1, A_MSK, 32'h0000_0001);
    t = 0;
    while (irq !== 1'b1 && t < 200) begin @(posedge core_clk_i); t++; end
    `CHK(t >= 1 && t <= p + 6, 1'b1)
    idle <= 1'b0;
    $display("test timer done");
    end_sim();
  end
endmodule : gp_timer16_gated_test
